// *** core/spb_fifo.sv ***
// small first-in first-out buffer with valid/ready on both sides
module spb_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [CW-1:0]           cnt;
    } spb_fifo_st_t;

    spb_fifo_st_t st_ff;
    spb_fifo_st_t nxt_st;
    logic         push;
    logic         pop;

    assign in_ready  = (st_ff.cnt != CW'(DEPTH));
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = st_ff.mem[st_ff.rd];
    assign level     = st_ff.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == PW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = (st_ff.rd == PW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
        end
        case ({push, pop})
            2'b10:   nxt_st.cnt = st_ff.cnt + 1'b1;
            2'b01:   nxt_st.cnt = st_ff.cnt - 1'b1;
            default: nxt_st.cnt = st_ff.cnt;
        endcase
    end

    // storage needs no reset, only the pointers and the count do
    always_ff @(posedge clock) begin
        st_ff <= nxt_st;
        if (!rst_n) begin
            st_ff.wr  <= '0;
            st_ff.rd  <= '0;
            st_ff.cnt <= '0;
        end
    end
endmodule

// *** core/spb_pkg.sv ***
// shared constants and carrier types of the segmented packet bus
package spb_pkg;
    localparam int SEG_N       = 4;
    localparam int SEG_W       = 128;
    localparam int MTY_W       = 4;
    localparam int SEG_BYTES   = 16;
    localparam int TX_SLACK    = 4;
    localparam int FIFO_DEPTH  = 4;
    localparam int LEN_W       = 16;
    localparam int RX_LEN_MIN  = 64;
    localparam int RX_LEN_MAX  = 9216;
    localparam int CNT_W       = 3;
    localparam logic [MTY_W-1:0] MTY_NONE = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RST  = 3'h0;

    typedef struct packed {
        logic [SEG_W-1:0] data;
        logic             ena;
        logic             sop;
        logic             eop;
        logic             err;
        logic [MTY_W-1:0] mty;
    } spb_seg_t;

    typedef spb_seg_t [SEG_N-1:0] spb_beat_t;

    localparam int BEAT_W = $bits(spb_beat_t);
endpackage

// *** core/spb_top.sv ***
// user-side segmented packet bus of the mac, transmit and receive
//
// Functional notes
// - capture transmit only where segment valid high
// - byte one sits in bits 127:120
// - empty count n voids bits 8n-1:0
// - error on end beat drops the packet
// - overflow raised when write limit is exceeded
// - receive outputs meaningful only when valid high
// - short receive packets flag start, end together
// - receive fills segments, empty count on end
// - receive error on fcs, length, code faults
// - segments used in order from zero
// - shared ready/overflow; honour with all valids low
// - receive may show cycles with no segment
// - everything on the rising clock edge
module spb_top
    import spb_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int SLACK = TX_SLACK
) (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire spb_pkg::spb_beat_t tx_seg_in,
    output logic                    tx_rdy,
    output logic                    tx_ovf,
    output spb_pkg::spb_beat_t      tx_line_beat,
    output logic                    tx_line_valid,
    input  wire logic               tx_line_ready,
    input  wire logic               rx_line_valid,
    input  wire spb_pkg::spb_beat_t rx_line_beat,
    output spb_pkg::spb_beat_t      rx_seg_out
);
    import spb_pkg::*;

    localparam int LW = $clog2(DEPTH+1);
    localparam logic [LEN_W-1:0] LEN_MIN = LEN_W'(RX_LEN_MIN);
    localparam logic [LEN_W-1:0] LEN_MAX = LEN_W'(RX_LEN_MAX);
    localparam logic [LEN_W-1:0] LEN_SAT = LEN_W'(RX_LEN_MAX + 1);
    localparam logic [LEN_W-1:0] SEG_LEN = LEN_W'(SEG_BYTES);
    localparam logic [CNT_W-1:0] SLACK_N = CNT_W'(SLACK);

    typedef struct packed {
        spb_beat_t        tx_out;
        logic             tx_out_vld;
        logic [CNT_W-1:0] late_wr;
        logic             ovf;
        spb_beat_t        rx_out;
        logic [LEN_W-1:0] rx_len;
        logic             rx_perr;
    } spb_st_t;

    spb_st_t          st_ff;
    spb_st_t          nxt_st;
    spb_beat_t        tx_clean;
    spb_beat_t        fifo_beat;
    logic             tx_push;
    logic             fifo_in_rdy;
    logic             fifo_out_vld;
    logic             fifo_pop;
    logic [LW-1:0]    fifo_level;
    logic [BEAT_W-1:0] fifo_out_raw;
    logic [SEG_N:0][LEN_W-1:0] rx_len_ch;
    logic [SEG_N:0]            rx_perr_ch;
    spb_beat_t                 rx_next;

    // receive chain starts from what the previous beat left open
    assign rx_len_ch[0]  = st_ff.rx_len;
    assign rx_perr_ch[0] = st_ff.rx_perr;

    // per segment: qualify transmit by its own valid, and extend the
    // receive length and fault chain in bus order
    generate
        for (genvar s = 0; s < SEG_N; s++) begin : g_seg
            logic             rx_take;
            logic [LEN_W-1:0] rx_base;
            logic [LEN_W-1:0] rx_bytes;
            logic [LEN_W-1:0] rx_sum;
            logic [LEN_W-1:0] rx_grown;
            logic             rx_fault;
            logic             rx_bad;

            always_comb begin
                tx_clean[s] = '0;
                if (tx_seg_in[s].ena) begin
                    tx_clean[s].data = tx_seg_in[s].data;
                    tx_clean[s].ena  = 1'b1;
                    tx_clean[s].sop  = tx_seg_in[s].sop;
                    tx_clean[s].eop  = tx_seg_in[s].eop;
                    tx_clean[s].err  = tx_seg_in[s].eop && tx_seg_in[s].err;
                    // empty count only matters on a clean end beat
                    if (tx_seg_in[s].eop && !tx_seg_in[s].err) begin
                        tx_clean[s].mty = tx_seg_in[s].mty;
                    end else begin
                        tx_clean[s].mty = MTY_NONE;
                    end
                end
            end

            assign rx_take  = rx_line_valid && rx_line_beat[s].ena;
            // a start drops whatever an earlier packet left behind
            assign rx_base  = rx_line_beat[s].sop ? '0 : rx_len_ch[s];
            assign rx_bytes = rx_line_beat[s].eop
                              ? SEG_LEN - LEN_W'(rx_line_beat[s].mty)
                              : SEG_LEN;
            assign rx_sum   = rx_base + rx_bytes;
            // saturate so a runaway frame cannot wrap back into range
            assign rx_grown = (rx_sum > LEN_MAX) ? LEN_SAT : rx_sum;
            assign rx_fault = (!rx_line_beat[s].sop && rx_perr_ch[s])
                              || rx_line_beat[s].err;
            assign rx_bad   = rx_fault || (rx_grown < LEN_MIN)
                              || (rx_grown > LEN_MAX);
            assign rx_len_ch[s+1]  = rx_take ? rx_grown : rx_len_ch[s];
            assign rx_perr_ch[s+1] = rx_take ? rx_fault : rx_perr_ch[s];

            always_comb begin
                rx_next[s] = '0;
                if (rx_take) begin
                    rx_next[s].data = rx_line_beat[s].data;
                    rx_next[s].ena  = 1'b1;
                    rx_next[s].sop  = rx_line_beat[s].sop;
                    rx_next[s].eop  = rx_line_beat[s].eop;
                    if (rx_line_beat[s].eop) begin
                        // fcs, code or length fault marks the end beat
                        rx_next[s].err = rx_bad;
                        rx_next[s].mty = rx_line_beat[s].mty;
                        if (rx_bad) begin
                            rx_next[s].mty[2:0] = 3'h0;
                        end
                    end
                end
            end
        end
    endgenerate

    // a beat carries data whenever any segment is active
    assign tx_push = |{tx_seg_in[0].ena, tx_seg_in[1].ena,
                       tx_seg_in[2].ena, tx_seg_in[3].ena};

    // ready only with the whole store empty: the fifo plus the output
    // register give room for the ready beat and the four late ones.
    // this trades throughput for a tiny store.
    assign tx_rdy = (fifo_level == '0) && !st_ff.tx_out_vld;

    spb_fifo #(
        .W     (BEAT_W),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (tx_push),
        .in_ready  (fifo_in_rdy),
        .in_data   (tx_clean),
        .out_valid (fifo_out_vld),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_raw),
        .level     (fifo_level)
    );

    assign fifo_beat = spb_beat_t'(fifo_out_raw);
    assign fifo_pop  = fifo_out_vld
                       && (!st_ff.tx_out_vld || tx_line_ready);

    always_comb begin
        nxt_st = st_ff;

        // transmit output register; an err-marked end tells the framer
        // to discard the whole packet rather than send it
        if (fifo_pop) begin
            nxt_st.tx_out     = fifo_beat;
            nxt_st.tx_out_vld = 1'b1;
        end else if (tx_line_ready) begin
            nxt_st.tx_out_vld = 1'b0;
        end

        // back-pressure policing
        if (tx_rdy) begin
            nxt_st.late_wr = CNT_RST;
        end else if (tx_push) begin
            if (st_ff.late_wr == SLACK_N) begin
                nxt_st.ovf = 1'b1;
            end else begin
                nxt_st.late_wr = st_ff.late_wr + 1'b1;
            end
        end
        // a push into a full store loses data, so it is an overflow too
        if (tx_push && !fifo_in_rdy) begin
            nxt_st.ovf = 1'b1;
        end
        if (st_ff.ovf) begin
            nxt_st.ovf = 1'b1;
        end

        // receive: segments pass in order, outputs zero when not valid
        nxt_st.rx_out  = rx_next;
        nxt_st.rx_len  = rx_len_ch[SEG_N];
        nxt_st.rx_perr = rx_perr_ch[SEG_N];
    end

    // all state moves on the rising edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tx_ovf        = st_ff.ovf;
    assign tx_line_beat  = st_ff.tx_out;
    assign tx_line_valid = st_ff.tx_out_vld;
    assign rx_seg_out    = st_ff.rx_out;
endmodule

// *** verif/spb_sink.sv ***
// framer-side sink model that takes beats and stalls on command
module spb_sink
    import spb_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               stall,
    input  wire logic               valid,
    input  wire spb_pkg::spb_beat_t beat,
    output logic                    ready,
    output logic                    got,
    output spb_pkg::spb_beat_t      seen
);
    assign ready = !stall;
    always_ff @(posedge clock) begin
        got <= rst_n && valid && ready;
        if (valid && ready)
            seen <= beat;
    end
endmodule

// *** verif/spb_top_monitor.sv ***
// assertion checker on the ports of the packet bus top
module spb_mon
    import spb_pkg::*;
#(
    parameter int SLACK = TX_SLACK
) (
    input wire logic               clock,
    input wire logic               rst_n,
    input wire spb_pkg::spb_beat_t tx_seg_in,
    input wire logic               tx_rdy,
    input wire logic               tx_ovf,
    input wire spb_pkg::spb_beat_t tx_line_beat,
    input wire logic               tx_line_valid,
    input wire logic               tx_line_ready,
    input wire logic               rx_line_valid,
    input wire spb_pkg::spb_beat_t rx_line_beat,
    input wire spb_pkg::spb_beat_t rx_seg_out
);
    logic             push;
    logic [CNT_W-1:0] late_ff;
    logic [CNT_W-1:0] nxt_late;
    assign push = tx_seg_in[0].ena | tx_seg_in[1].ena
                | tx_seg_in[2].ena | tx_seg_in[3].ena;
    // saturate so a long abuse run cannot wrap back to legal
    always_comb begin
        nxt_late = late_ff;
        if (tx_rdy)
            nxt_late = CNT_RST;
        else if (push && late_ff != 3'h7)
            nxt_late = late_ff + 3'h1;
    end
    always_ff @(posedge clock)
        late_ff <= rst_n ? nxt_late : CNT_RST;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_short_rx;
        rx_line_valid && rx_line_beat[0].ena
        && rx_line_beat[0].sop && rx_line_beat[0].eop;
    endsequence
    sequence s_stall;
        tx_line_valid && !tx_line_ready;
    endsequence
    a_rx_short_err: assert property (s_short_rx |=> rx_seg_out[0].err)
        else $error("short receive packet not flagged");
    a_rx_idle_zero: assert property (!rx_line_valid |=> rx_seg_out == '0)
        else $error("receive output not quiet");
    a_rx_err_mty: assert property (rx_seg_out[0].err |->
        rx_seg_out[0].mty[2:0] == 3'h0) else $error("rx empty count kept");
    a_tx_drop_mty: assert property (tx_line_valid && tx_line_beat[1].err
        |-> tx_line_beat[1].mty == MTY_NONE) else $error("tx empty kept");
    a_tx_idle_seg: assert property (tx_line_valid && !tx_line_beat[3].ena
        |-> tx_line_beat[3] == '0) else $error("idle segment leaked");
    a_line_hold: assert property (s_stall |=>
        tx_line_valid && $stable(tx_line_beat)) else $error("beat moved");
    a_rdy_fall: assert property (push |=> !tx_rdy)
        else $error("ready stayed high after push");
    a_ovf_late: assert property (push && !tx_rdy && late_ff == SLACK
        |=> tx_ovf) else $error("overflow missed");
    a_ovf_cause: assert property ($rose(tx_ovf) |-> $past(push))
        else $error("overflow without write");
    a_ovf_hold: assert property (tx_ovf |=> tx_ovf)
        else $error("overflow dropped");
endmodule
bind spb_top spb_mon #(.SLACK(SLACK)) mon_u (.clock(clock), .rst_n(rst_n),
    .tx_seg_in(tx_seg_in), .tx_rdy(tx_rdy), .tx_ovf(tx_ovf),
    .tx_line_beat(tx_line_beat), .tx_line_valid(tx_line_valid),
    .tx_line_ready(tx_line_ready), .rx_line_valid(rx_line_valid),
    .rx_line_beat(rx_line_beat), .rx_seg_out(rx_seg_out));

// *** verif/test_spb_top.sv ***
// self-checking bench for the packet bus top
module test_spb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spb_pkg::*;
    logic clock, rst_n, rdy, ovf, lvalid, lready, rvalid, stall, hold, got;
    spb_beat_t tx_in, lbeat, rbeat, rout, seen;
    int errors, tests_run, cyc;
    integer seed;
    spb_top dut_u (.clock(clock), .rst_n(rst_n), .tx_seg_in(tx_in),
        .tx_rdy(rdy), .tx_ovf(ovf), .tx_line_beat(lbeat),
        .tx_line_valid(lvalid), .tx_line_ready(lready),
        .rx_line_valid(rvalid), .rx_line_beat(rbeat), .rx_seg_out(rout));
    spb_sink sink_u (.clock(clock), .rst_n(rst_n), .stall(stall),
        .valid(lvalid), .beat(lbeat), .ready(lready), .got(got), .seen(seen));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        stall <= hold | 1'($random(seed));
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            wrap_up();
        end
    end
    function automatic spb_beat_t mk(input logic [3:0] e, s, p, r);
        for (int i = 0; i < SEG_N; i++) begin
            mk[i].data = {4{$random(seed)}};
            mk[i].ena = e[i];
            mk[i].sop = s[i];
            mk[i].eop = p[i];
            mk[i].err = r[i];
            mk[i].mty = p[i] ? MTY_W'($random(seed)) : MTY_NONE;
        end
    endfunction
    function automatic spb_beat_t tx_exp(input spb_beat_t b);
        tx_exp = b;
        for (int i = 0; i < SEG_N; i++)
            if (!b[i].ena) tx_exp[i] = '0;
            else if (b[i].err || !b[i].eop) tx_exp[i].mty = MTY_NONE;
    endfunction
    function automatic spb_beat_t rx_exp(input spb_beat_t b, input logic e);
        rx_exp = b;
        for (int i = 0; i < SEG_N; i++) begin
            rx_exp[i].err = b[i].eop & e;
            if (rx_exp[i].err) rx_exp[i].mty[2:0] = 3'h0;
            if (!b[i].ena) rx_exp[i] = '0;
        end
    endfunction
    task automatic check(input string what, input logic [BEAT_W-1:0] exp,
                         input logic [BEAT_W-1:0] seen_v);
        tests_run++;
        if (seen_v !== exp) begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen_v);
        end
    endtask
    // back to back pushes, then junk flags with every valid low
    task automatic tx_send(input spb_beat_t b, input int n);
        repeat (n) @(posedge clock) tx_in <= b;
        @(posedge clock) tx_in <= mk(4'h0, 4'hF, 4'hF, 4'hF);
    endtask
    // a 64 byte head, then the tail as one late write: no short frames
    task automatic tx_one(input spb_beat_t b);
        spb_beat_t h;
        h = mk(4'hF, 4'h1, 4'h0, 4'h0);
        @(posedge clock) tx_in <= h;
        tx_send(b, 1);
        for (int k = 0; k < 2; k++) begin
            repeat (20) begin
                @(posedge clock);
                #1;
                if (got === 1'b1) break;
            end
            check("tx beat", tx_exp(k ? b : h), seen);
        end
        check("tx ready", 1'b1, rdy);
    endtask
    task automatic rx_put(input spb_beat_t b, input logic e);
        @(posedge clock);
        rvalid <= 1'b1;
        rbeat <= b;
        @(posedge clock);
        rvalid <= 1'b0;
        rbeat <= ~b;
        #1 check("rx seg", rx_exp(b, e), rout);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        cyc = 0;
        seed = 32'h96E1;
        {rst_n, rvalid, hold} = 3'h0;
        tx_in = '0;
        rbeat = '0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++)
            case (i % 3)
                0: tx_one(mk(4'h1, 4'h0, 4'h1, 4'h0));
                1: tx_one(mk(4'h3, 4'h0, 4'h2, 4'h2));
                default: tx_one(mk(4'h7, 4'h0, 4'h4, 4'h0));
            endcase
        $display("tx beats done");
        hold <= 1'b1;
        repeat (2) @(posedge clock);
        tx_send(mk(4'hF, 4'h0, 4'h0, 4'h0), 5);
        repeat (2) @(posedge clock);
        #1 check("ovf legal", 1'b0, ovf);
        tx_send(mk(4'hF, 4'h0, 4'h0, 4'h0), 1);
        repeat (6) @(posedge clock);
        #1 check("ovf set", 1'b1, ovf);
        @(posedge clock) rst_n <= 1'b0;
        @(posedge clock) rst_n <= 1'b1;
        hold <= 1'b0;
        #1 check("ovf reset", 2'h1, {ovf, rdy});
        $display("overflow done");
        rx_put(mk(4'h1, 4'h1, 4'h1, 4'h0), 1'b1);
        for (int i = 0; i < 2; i++) begin
            rx_put(mk(4'hF, 4'h1, 4'h0, 4'h0), 1'b0);
            rx_put(mk(4'hF, 4'h0, 4'h8, {2'h0, i[0], 1'b0}), i[0]);
        end
        $display("rx done");
        wrap_up();
    end
endmodule
